// File: logic/cf_top.sv
// How it works
// - Preset mode loads both offsets with 64, 16 or 8 at reset release.
// - Select high, both flag selects low at reset release picks parallel.
// - After the two offset writes, the third write stores FIFO data.
// - Parallel offsets come from low port A data bits, top bit MSB.
// - Select low, sel0 low, sel1 high picks serial; others reserved.
// - Serial mode shifts one bit per port A edge with strobe low.
// - Sixteen serial bits: almost-full offset first, almost-empty second.
// - Full flag stays low until all serial bits loaded, then rises.
// - Port A data driven only when select and write/read both low.
// - FIFO write needs select low, write, strobe, no mailbox, full high.
// - Port B data driven only when select low and write/read high.
// - FIFO read needs select low, read, strobe, no mailbox, empty high.
// - Strobe low means no transfer on that port edge.
// - Fall-through with ready low loads next word and raises ready.
// - Standard mode moves words to output only on selected reads.
// - Flags pass two flops, each timed to its own port clock.
// - Fall-through ready low means old word held, reads ignored.
// - Standard empty flag high while memory holds a readable word.
// - Port A mailbox: write mail 1, or read mail 2 setting its flag.
// - Port B mailbox: write mail 2, or read mail 1 setting its flag.
// - Straps latched on master reset release pick offset method.
// - Parallel mode: first two writes load offsets, not memory.
// - Timing select level at next port B edge picks standard or fall-through.
`timescale 1ns/100ps
module cf_top (
  // Clock and reset
  input  wire logic                      i_mclk,
  input  wire logic                      i_nrst,
  // Master reset and straps
  input  wire logic                      i_master_reset1_n,
  input  wire logic                      i_serial_prog_mode_n,
  input  wire logic                      i_flag_sel0_serial_data,
  input  wire logic                      i_flag_sel1_serial_strobe_n,
  input  wire logic                      i_endian_timing_select,
  // Port A
  input  wire logic                      i_port_a_clock,
  input  wire logic                      i_port_a_select_n,
  input  wire logic                      i_port_a_write_read,
  input  wire logic                      i_port_a_strobe_on,
  input  wire logic                      i_port_a_mailbox_select,
  input  wire logic [cf_pkg::DATA_W-1:0] i_port_a_data,
  output logic      [cf_pkg::DATA_W-1:0] o_port_a_data,
  output logic                           o_port_a_data_oe_n,
  // Port B
  input  wire logic                      i_port_b_clock,
  input  wire logic                      i_port_b_select_n,
  input  wire logic                      i_port_b_write_read_n,
  input  wire logic                      i_port_b_strobe_on,
  input  wire logic                      i_port_b_mailbox_select,
  input  wire logic [cf_pkg::DATA_W-1:0] i_port_b_data,
  output logic      [cf_pkg::DATA_W-1:0] o_port_b_data,
  output logic                           o_port_b_data_oe_n,
  // Flags
  output logic                           o_full_input_ready,
  output logic                           o_almost_full_n,
  output logic                           o_empty_output_ready,
  output logic                           o_almost_empty_n,
  output logic                           o_mail1_flag_n,
  output logic                           o_mail2_flag_n
);

  localparam int DW = cf_pkg::DATA_W;
  localparam int AW = cf_pkg::ADDR_W;
  localparam int CW = cf_pkg::CNT_W;
  localparam int OW = cf_pkg::OFS_W;

  // Pin sampling: three flops, a bit changes once stages 2 and 3 agree
  cf_pkg::cf_port_t  a_pin, a_s1_reg, a_s2_reg, a_s3_reg, a_reg, a_next;
  cf_pkg::cf_port_t  b_pin, b_s1_reg, b_s2_reg, b_s3_reg, b_reg, b_next;
  cf_pkg::cf_strap_t st_pin, st_s1_reg, st_s2_reg, st_s3_reg, st_reg, st_next;
  logic              a_clk_prev_reg, b_clk_prev_reg, rst_prev_reg;

  function automatic cf_pkg::cf_port_t settle_port(
    input cf_pkg::cf_port_t s2,
    input cf_pkg::cf_port_t s3,
    input cf_pkg::cf_port_t acc
  );
    settle_port = (s2 & s3) | (acc & (s2 | s3));
  endfunction : settle_port

  assign a_pin  = '{i_port_a_clock, i_port_a_select_n, i_port_a_write_read,
                    i_port_a_strobe_on, i_port_a_mailbox_select, i_port_a_data};
  assign b_pin  = '{i_port_b_clock, i_port_b_select_n, i_port_b_write_read_n,
                    i_port_b_strobe_on, i_port_b_mailbox_select, i_port_b_data};
  assign st_pin = '{i_master_reset1_n, i_serial_prog_mode_n,
                    i_flag_sel0_serial_data, i_flag_sel1_serial_strobe_n,
                    i_endian_timing_select};

  always_comb begin
    a_next  = settle_port(a_s2_reg, a_s3_reg, a_reg);
    b_next  = settle_port(b_s2_reg, b_s3_reg, b_reg);
    st_next = (st_s2_reg & st_s3_reg) | (st_reg & (st_s2_reg | st_s3_reg));
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      a_s1_reg <= '0; a_s2_reg <= '0; a_s3_reg <= '0; a_reg <= '0;
      b_s1_reg <= '0; b_s2_reg <= '0; b_s3_reg <= '0; b_reg <= '0;
      st_s1_reg <= '0; st_s2_reg <= '0; st_s3_reg <= '0; st_reg <= '0;
      a_clk_prev_reg <= 1'b0;
      b_clk_prev_reg <= 1'b0;
      rst_prev_reg   <= 1'b0;
    end else begin
      a_s1_reg <= a_pin; a_s2_reg <= a_s1_reg; a_s3_reg <= a_s2_reg;
      b_s1_reg <= b_pin; b_s2_reg <= b_s1_reg; b_s3_reg <= b_s2_reg;
      st_s1_reg <= st_pin; st_s2_reg <= st_s1_reg; st_s3_reg <= st_s2_reg;
      a_reg  <= a_next;
      b_reg  <= b_next;
      st_reg <= st_next;
      a_clk_prev_reg <= a_reg.clk;
      b_clk_prev_reg <= b_reg.clk;
      rst_prev_reg   <= st_reg.reset_n;
    end
  end

  // Port events
  logic a_edge, b_edge, mreset, rst_rise, a_sel, b_sel;
  logic fifo_wr_sel, mail1_wr, mail2_rd, rd_sel, mail1_rd, mail2_wr;
  logic full_reg, rflag_reg;

  assign a_edge   = a_reg.clk & ~a_clk_prev_reg;
  assign b_edge   = b_reg.clk & ~b_clk_prev_reg;
  assign mreset   = ~st_reg.reset_n;
  assign rst_rise = st_reg.reset_n & ~rst_prev_reg;
  assign a_sel    = a_edge & ~a_reg.sel_n & a_reg.strobe;
  assign b_sel    = b_edge & ~b_reg.sel_n & b_reg.strobe;
  assign fifo_wr_sel = a_sel & a_reg.dir & ~a_reg.mbox & full_reg;
  assign mail1_wr = a_sel & a_reg.dir & a_reg.mbox;
  assign mail2_rd = a_sel & ~a_reg.dir & a_reg.mbox;
  assign rd_sel   = b_sel & b_reg.dir & ~b_reg.mbox;
  assign mail1_rd = b_sel & b_reg.dir & b_reg.mbox;
  assign mail2_wr = b_sel & ~b_reg.dir & b_reg.mbox;

  // Offset programming
  cf_pkg::cf_prog_t  mode_reg, mode_next;
  logic [OW-1:0]     ofs_x_reg, ofs_x_next, ofs_y_reg, ofs_y_next;
  logic [2*OW-1:0]   ser_reg, ser_next;
  logic [4:0]        ser_cnt_reg, ser_cnt_next;
  logic              par_cnt_reg, par_cnt_next;
  logic              done_reg, done_next, fwft_reg, fwft_next;
  logic              tsel_pend_reg, tsel_pend_next;

  function automatic cf_pkg::cf_prog_t decode_mode(input cf_pkg::cf_strap_t s);
    if (!s.spm_n) begin
      decode_mode = ( s.flag_sel1_serial_strobe_n_n && !s.flag_sel0_serial_data) ? cf_pkg::CF_SERIAL
                                                : cf_pkg::CF_RESERVED;
    end else if (!s.flag_sel1_serial_strobe_n_n && !s.flag_sel0_serial_data) begin
      decode_mode = cf_pkg::CF_PARALLEL;
    end else begin
      decode_mode = cf_pkg::CF_PRESET;
    end
  endfunction : decode_mode

  always_comb begin
    mode_next      = mode_reg;
    ofs_x_next     = ofs_x_reg;
    ofs_y_next     = ofs_y_reg;
    ser_next       = ser_reg;
    ser_cnt_next   = ser_cnt_reg;
    par_cnt_next   = par_cnt_reg;
    done_next      = done_reg;
    fwft_next      = fwft_reg;
    tsel_pend_next = tsel_pend_reg;
    if (rst_rise) begin
      mode_next      = decode_mode(st_reg);
      ser_cnt_next   = '0;
      par_cnt_next   = 1'b0;
      tsel_pend_next = 1'b1;
      done_next      = 1'b0;
      case (decode_mode(st_reg))
        cf_pkg::CF_PRESET: begin
          done_next = 1'b1;
          if (st_reg.flag_sel1_serial_strobe_n_n && st_reg.flag_sel0_serial_data) begin
            ofs_x_next = cf_pkg::OFS_64;
          end else if (st_reg.flag_sel1_serial_strobe_n_n) begin
            ofs_x_next = cf_pkg::OFS_16;
          end else begin
            ofs_x_next = cf_pkg::OFS_8;
          end
          ofs_y_next = ofs_x_next;
        end
        // Reserved strapping falls back to the smallest preset
        cf_pkg::CF_RESERVED: begin
          done_next  = 1'b1;
          ofs_x_next = cf_pkg::OFS_8;
          ofs_y_next = cf_pkg::OFS_8;
        end
        default: begin
          done_next = 1'b0;
        end
      endcase
    end else if (mreset) begin
      done_next      = 1'b0;
      tsel_pend_next = 1'b0;
    end else begin
      if (tsel_pend_reg && b_edge) begin
        fwft_next      = ~st_reg.tsel;
        tsel_pend_next = 1'b0;
      end
      if (!done_reg && mode_reg == cf_pkg::CF_SERIAL && a_edge
          && !st_reg.flag_sel1_serial_strobe_n_n) begin
        ser_next     = {ser_reg[2*OW-2:0], st_reg.flag_sel0_serial_data};
        ser_cnt_next = ser_cnt_reg + cf_pkg::SER_ONE;
        if (ser_cnt_reg == cf_pkg::SER_LAST) begin
          ofs_y_next = ser_next[2*OW-1:OW];
          ofs_x_next = ser_next[OW-1:0];
          done_next  = 1'b1;
        end
      end
      if (!done_reg && mode_reg == cf_pkg::CF_PARALLEL && fifo_wr_sel) begin
        par_cnt_next = 1'b1;
        if (!par_cnt_reg) begin
          ofs_y_next = a_reg.data[OW-1:0];
        end else begin
          ofs_x_next = a_reg.data[OW-1:0];
          done_next  = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      mode_reg      <= cf_pkg::CF_PRESET;
      ofs_x_reg     <= cf_pkg::OFS_8;
      ofs_y_reg     <= cf_pkg::OFS_8;
      ser_reg       <= '0;
      ser_cnt_reg   <= '0;
      par_cnt_reg   <= 1'b0;
      done_reg      <= 1'b0;
      fwft_reg      <= 1'b0;
      tsel_pend_reg <= 1'b0;
    end else begin
      mode_reg      <= mode_next;
      ofs_x_reg     <= ofs_x_next;
      ofs_y_reg     <= ofs_y_next;
      ser_reg       <= ser_next;
      ser_cnt_reg   <= ser_cnt_next;
      par_cnt_reg   <= par_cnt_next;
      done_reg      <= done_next;
      fwft_reg      <= fwft_next;
      tsel_pend_reg <= tsel_pend_next;
    end
  end

  // Write buffer and memory
  logic          buf_in_valid, buf_in_ready, buf_out_valid, push;
  logic [DW-1:0] buf_out_data, rdata;
  logic [1:0]    buf_cnt;
  logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [CW-1:0] count_reg, count_next, occ;
  logic          load, nonempty;

  assign buf_in_valid = fifo_wr_sel & done_reg;
  assign push     = buf_out_valid & (count_reg != cf_pkg::DEPTH_CNT);
  assign occ      = count_reg + {{(CW-2){1'b0}}, buf_cnt};
  assign nonempty = (count_reg != '0);

  cf_skid #(.W(DW)) u_skid (
    .i_clk   (i_mclk),
    .i_nrst  (i_nrst),
    .i_flush (mreset),
    .i_valid (buf_in_valid),
    .o_ready (buf_in_ready),
    .i_data  (a_reg.data),
    .o_valid (buf_out_valid),
    .i_ready (count_reg != cf_pkg::DEPTH_CNT),
    .o_data  (buf_out_data),
    .o_count (buf_cnt)
  );

  cf_mem #(.AW(AW), .W(DW)) u_mem (
    .i_clk   (i_mclk),
    .i_we    (push),
    .i_waddr (wr_ptr_reg),
    .i_wdata (buf_out_data),
    .i_raddr (rd_ptr_reg),
    .o_rdata (rdata)
  );

  // Flag first stages on the system clock, second on the port edge
  logic ne_s_reg, ae_s_reg, af_s_reg, ff_s_reg, ff_raw;
  logic af_reg, ae_reg, af_next, ae_next, full_next, rflag_next;
  logic [DW-1:0] out_reg, out_next;

  // Room for the words still in the buffer keeps it from overflowing
  assign ff_raw = ~mreset & buf_in_ready & (occ < cf_pkg::DEPTH_CNT)
                & (done_reg | mode_reg == cf_pkg::CF_PARALLEL);

  always_comb begin
    load       = 1'b0;
    rflag_next = rflag_reg;
    out_next   = out_reg;
    if (fwft_reg) begin
      if (!rflag_reg) begin
        load       = b_edge & ne_s_reg & nonempty;
        rflag_next = load;
      end else if (rd_sel) begin
        load       = ne_s_reg & nonempty;
        rflag_next = load;
      end
    end else begin
      load = rd_sel & rflag_reg & nonempty;
      if (b_edge) begin
        rflag_next = ne_s_reg & ~(load && count_reg == cf_pkg::CNT_ONE);
      end
    end
    if (load) begin
      out_next = rdata;
    end
    wr_ptr_next = wr_ptr_reg + (push ? cf_pkg::PTR_ONE : '0);
    rd_ptr_next = rd_ptr_reg + (load ? cf_pkg::PTR_ONE : '0);
    count_next  = count_reg + (push ? cf_pkg::CNT_ONE : '0)
                            - (load ? cf_pkg::CNT_ONE : '0);
    full_next   = a_edge ? ff_s_reg : full_reg;
    af_next     = a_edge ? af_s_reg : af_reg;
    ae_next     = b_edge ? ae_s_reg : ae_reg;
    if (mreset) begin
      wr_ptr_next = '0;
      rd_ptr_next = '0;
      count_next  = '0;
      rflag_next  = 1'b0;
      full_next   = 1'b0;
      af_next     = 1'b1;
      ae_next     = 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      out_reg    <= '0;
      rflag_reg  <= 1'b0;
      full_reg   <= 1'b0;
      af_reg     <= 1'b1;
      ae_reg     <= 1'b0;
      ne_s_reg   <= 1'b0;
      ae_s_reg   <= 1'b0;
      af_s_reg   <= 1'b1;
      ff_s_reg   <= 1'b0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
      out_reg    <= out_next;
      rflag_reg  <= rflag_next;
      full_reg   <= full_next;
      af_reg     <= af_next;
      ae_reg     <= ae_next;
      ne_s_reg   <= nonempty;
      ae_s_reg   <= (count_reg > {1'b0, ofs_x_reg});
      af_s_reg   <= (count_reg < cf_pkg::DEPTH_CNT - {1'b0, ofs_y_reg});
      ff_s_reg   <= ff_raw;
    end
  end

  // Mailboxes and data pins
  logic [DW-1:0] mail1_reg, mail1_next, mail2_reg, mail2_next;
  logic          mail1_flag_n_reg, mail1_flag_n_next, mail2_flag_n_reg, mail2_flag_n_next;
  logic [DW-1:0] pa_out_next, pb_out_next;

  always_comb begin
    mail1_next  = mail1_wr ? a_reg.data : mail1_reg;
    mail2_next  = mail2_wr ? b_reg.data : mail2_reg;
    // A write landing with a read keeps the flag low
    mail1_flag_n_next   = mail1_wr ? 1'b0 : (mail1_rd ? 1'b1 : mail1_flag_n_reg);
    mail2_flag_n_next   = mail2_wr ? 1'b0 : (mail2_rd ? 1'b1 : mail2_flag_n_reg);
    if (mreset) begin
      mail1_flag_n_next = 1'b1;
      mail2_flag_n_next = 1'b1;
    end
    pa_out_next = mail2_reg;
    pb_out_next = b_reg.mbox ? mail1_reg : out_reg;
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      mail1_reg          <= '0;
      mail2_reg          <= '0;
      mail1_flag_n_reg           <= 1'b1;
      mail2_flag_n_reg           <= 1'b1;
      o_port_a_data      <= '0;
      o_port_b_data      <= '0;
      o_port_a_data_oe_n <= 1'b1;
      o_port_b_data_oe_n <= 1'b1;
    end else begin
      mail1_reg          <= mail1_next;
      mail2_reg          <= mail2_next;
      mail1_flag_n_reg           <= mail1_flag_n_next;
      mail2_flag_n_reg           <= mail2_flag_n_next;
      o_port_a_data      <= pa_out_next;
      o_port_b_data      <= pb_out_next;
      o_port_a_data_oe_n <= a_reg.sel_n | a_reg.dir;
      o_port_b_data_oe_n <= b_reg.sel_n | ~b_reg.dir;
    end
  end

  assign o_full_input_ready   = full_reg;
  assign o_almost_full_n      = af_reg;
  assign o_empty_output_ready = rflag_reg;
  assign o_almost_empty_n     = ae_reg;
  assign o_mail1_flag_n       = mail1_flag_n_reg;
  assign o_mail2_flag_n       = mail2_flag_n_reg;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  property p_wr_gate;
    buf_in_valid |-> full_reg && done_reg && a_reg.strobe;
  endproperty
  a_wr_gate: assert property (p_wr_gate) else $error("write while not ready");

  property p_std_read;
    (load && !fwft_reg) |-> (rflag_reg && rd_sel);
  endproperty
  a_std_read: assert property (p_std_read) else $error("bad standard read");

  property p_fwft_hold;
    (fwft_reg && !rflag_reg && !b_edge) |-> !load;
  endproperty
  a_fwft_hold: assert property (p_fwft_hold) else $error("load while held");

  property p_oe_a;
    (!a_reg.sel_n && !a_reg.dir) |=> !o_port_a_data_oe_n;
  endproperty
  a_oe_a: assert property (p_oe_a) else $error("port A not driving");

  property p_oe_b;
    (b_reg.sel_n || !b_reg.dir) |=> o_port_b_data_oe_n;
  endproperty
  a_oe_b: assert property (p_oe_b) else $error("port B driving");

  property p_serial_low;
    (mode_reg == cf_pkg::CF_SERIAL && !done_reg) ##1 !done_reg |-> !full_reg;
  endproperty
  a_serial_low: assert property (p_serial_low) else $error("ready early");

  property p_mail_set;
    mail1_wr |=> !o_mail1_flag_n ##1 !o_mail1_flag_n || $past(mail1_rd);
  endproperty
  a_mail_set: assert property (p_mail_set) else $error("mail flag high");

  property p_mail_clr;
    (mail2_rd && !mail2_wr && !mreset) |=> o_mail2_flag_n;
  endproperty
  a_mail_clr: assert property (p_mail_clr) else $error("mail2 not clear");

  property p_preset64;
    (rst_rise && st_reg.spm_n && st_reg.flag_sel0_serial_data && st_reg.flag_sel1_serial_strobe_n_n)
      |=> (ofs_x_reg == cf_pkg::OFS_64 && ofs_y_reg == cf_pkg::OFS_64);
  endproperty
  a_preset64: assert property (p_preset64) else $error("preset 64 lost");

  property p_full_sync;
    (!a_edge && !mreset) |=> $stable(full_reg) && $stable(af_reg);
  endproperty
  a_full_sync: assert property (p_full_sync) else $error("flag off edge");

endmodule : cf_top

// File: pkg/cf_pkg.sv
package cf_pkg;

  // Fixed at the 256-word variant
  localparam int DATA_W = 36;
  localparam int ADDR_W = 8;
  localparam int CNT_W  = 9;
  localparam int OFS_W  = 8;

  localparam logic [CNT_W-1:0] DEPTH_CNT = 9'h100;
  localparam logic [CNT_W-1:0] CNT_ONE   = 9'h001;
  localparam logic [ADDR_W-1:0] PTR_ONE  = 8'h01;

  // Preset offsets
  localparam logic [OFS_W-1:0] OFS_64 = 8'h40;
  localparam logic [OFS_W-1:0] OFS_16 = 8'h10;
  localparam logic [OFS_W-1:0] OFS_8  = 8'h08;

  // Serial load: almost-full offset bits first, then almost-empty
  localparam int SER_BITS = 2 * OFS_W;
  localparam logic [4:0] SER_LAST = 5'h0f;
  localparam logic [4:0] SER_ONE  = 5'h01;

  typedef enum logic [1:0] {
    CF_PRESET,
    CF_PARALLEL,
    CF_SERIAL,
    CF_RESERVED
  } cf_prog_t;

  // One port's pins as seen after sampling
  typedef struct packed {
    logic              clk;
    logic              sel_n;
    logic              dir;
    logic              strobe;
    logic              mbox;
    logic [DATA_W-1:0] data;
  } cf_port_t;

  // Master reset and the levels it latches
  typedef struct packed {
    logic reset_n;
    logic spm_n;
    logic flag_sel0_serial_data;
    logic flag_sel1_serial_strobe_n_n;
    logic tsel;
  } cf_strap_t;

endpackage : cf_pkg

// File: logic/cf_mem.sv
`timescale 1ns/100ps
module cf_mem #(
  parameter int AW = 8,
  parameter int W  = 36
) (
  // Clock
  input  wire logic          i_clk,
  // Write side
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [W-1:0]  i_wdata,
  // Read side
  input  wire logic [AW-1:0] i_raddr,
  output logic      [W-1:0]  o_rdata
);

  logic [W-1:0] mem_reg [2**AW];

  // Array itself is never reset, only the pointers are
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_reg[i_waddr] <= i_wdata;
    end
    o_rdata <= mem_reg[i_raddr];
  end

endmodule : cf_mem

// File: logic/cf_skid.sv
`timescale 1ns/100ps
module cf_skid #(
  parameter int W = 36
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_nrst,
  input  wire logic         i_flush,
  // Filling side
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  // Draining side
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic      [W-1:0] o_data,
  output logic      [1:0]   o_count
);

  logic [W-1:0] d0_reg, d0_next, d1_reg, d1_next;
  logic [1:0]   cnt_reg, cnt_next;
  logic         push, pop;

  assign o_ready = (cnt_reg != 2'h2);
  assign o_valid = (cnt_reg != 2'h0);
  assign o_data  = d0_reg;
  assign o_count = cnt_reg;
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;

  always_comb begin
    d0_next  = d0_reg;
    d1_next  = d1_reg;
    cnt_next = cnt_reg;
    if (i_flush) begin
      cnt_next = 2'h0;
    end else if (push && pop) begin
      if (cnt_reg == 2'h1) begin
        d0_next = i_data;
      end else begin
        d0_next = d1_reg;
        d1_next = i_data;
      end
    end else if (push) begin
      if (cnt_reg == 2'h0) begin
        d0_next = i_data;
      end else begin
        d1_next = i_data;
      end
      cnt_next = cnt_reg + 2'h1;
    end else if (pop) begin
      d0_next  = d1_reg;
      cnt_next = cnt_reg - 2'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      d0_reg  <= '0;
      d1_reg  <= '0;
      cnt_reg <= 2'h0;
    end else begin
      d0_reg  <= d0_next;
      d1_reg  <= d1_next;
      cnt_reg <= cnt_next;
    end
  end

endmodule : cf_skid

// File: bench/cf_partner.sv
`timescale 1ns/100ps
module cf_partner (
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_nrst,
  // Port clocks
  output logic      o_pa_clk,
  output logic      o_pb_clk
);
  logic [2:0] a_reg;
  logic [3:0] b_reg;
  // Unequal periods so the two port edges drift apart
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      a_reg <= 3'h0;
      b_reg <= 4'h0;
    end else begin
      a_reg <= a_reg + 3'h1;
      b_reg <= (b_reg == 4'h9) ? 4'h0 : b_reg + 4'h1;
    end
  end
  assign o_pa_clk = a_reg[2];
  assign o_pb_clk = (b_reg > 4'h4);
endmodule : cf_partner

// File: bench/testbench.sv
`timescale 1ns/100ps
module testbench;
  typedef struct packed {
    logic        stb;
    logic [35:0] d;
    logic [35:0] e;
  } cf_row_t;
  localparam logic [15:0] SER = 16'h0503;
  logic             i_mclk, i_nrst, mrst_n, spm_n, fs0, fs1, tsel, pac, pbc;
  logic             a_oe_n, b_oe_n, full, af_n, empty, ae_n, m1_n, m2_n;
  logic [35:0]      a_q, b_q;
  cf_pkg::cf_port_t pa, pb;
  int               failures = 0, n_checks = 0, cycles = 0;
  cf_row_t rows [3] = '{'{1'b1, 36'h111111111, 36'h111111111},
                        '{1'b0, 36'h222222222, 36'h111111111},
                        '{1'b1, 36'h333333333, 36'h333333333}};

  cf_partner i_far (.i_mclk, .i_nrst, .o_pa_clk(pac), .o_pb_clk(pbc));
  cf_top i_dut (
    .i_mclk, .i_nrst, .i_master_reset1_n(mrst_n),
    .i_serial_prog_mode_n(spm_n), .i_flag_sel0_serial_data(fs0),
    .i_flag_sel1_serial_strobe_n(fs1), .i_endian_timing_select(tsel),
    .i_port_a_clock(pac), .i_port_a_select_n(pa.sel_n),
    .i_port_a_write_read(pa.dir), .i_port_a_strobe_on(pa.strobe),
    .i_port_a_mailbox_select(pa.mbox), .i_port_a_data(pa.data),
    .o_port_a_data(a_q), .o_port_a_data_oe_n(a_oe_n),
    .i_port_b_clock(pbc), .i_port_b_select_n(pb.sel_n),
    .i_port_b_write_read_n(pb.dir), .i_port_b_strobe_on(pb.strobe),
    .i_port_b_mailbox_select(pb.mbox), .i_port_b_data(pb.data),
    .o_port_b_data(b_q), .o_port_b_data_oe_n(b_oe_n),
    .o_full_input_ready(full), .o_almost_full_n(af_n),
    .o_empty_output_ready(empty), .o_almost_empty_n(ae_n),
    .o_mail1_flag_n(m1_n), .o_mail2_flag_n(m2_n));

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [35:0] s, input logic [35:0] e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  // c = {select_n, direction, strobe, mailbox}; held past the port edge
  task automatic xfer(input bit b, input logic [3:0] c, input logic [35:0] v);
    if (b) @(negedge pbc); else @(negedge pac);
    @(posedge i_mclk);
    if (b) pb <= {1'b0, c, v}; else pa <= {1'b0, c, v};
    if (b) @(posedge pbc); else @(posedge pac);
    repeat (6) @(posedge i_mclk);
    if (b) pb.strobe <= 1'b0; else pa.strobe <= 1'b0;
    repeat (4) @(posedge i_mclk);
  endtask : xfer

  task automatic mreset(input logic [2:0] s);
    mrst_n <= 1'b0;
    {spm_n, fs1, fs0} <= s;
    repeat (8) @(posedge i_mclk);
    chk({full, empty, ae_n, af_n, m1_n, m2_n}, 36'h07);
    mrst_n <= 1'b1;
    repeat (12) @(posedge i_mclk);
    fs1 <= 1'b1;
    repeat (30) @(posedge i_mclk);
  endtask : mreset

  // Standard mode keeps every written word in memory until read
  task automatic fill(input int n, input int x);
    for (int k = 1; k <= n; k++) begin
      xfer(0, 4'b0110, 36'(k));
      repeat (30) @(posedge i_mclk);
      chk(ae_n, k > x);
    end
  endtask : fill

  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      report_and_stop();
    end
  end

  initial begin
    pa = {1'b0, 4'hc, 36'h0};
    pb = {1'b0, 4'hc, 36'h0};
    {i_nrst, mrst_n, spm_n, fs1, fs0, tsel} = 6'h1b;
    repeat (2) @(posedge i_mclk);
    i_nrst <= 1'b1;
    mreset(3'b101);
    chk(full, 1'b1);
    foreach (rows[i]) begin
      xfer(0, {2'b01, rows[i].stb, 1'b0}, rows[i].d);
      repeat (30) @(posedge i_mclk);
      xfer(1, 4'b0110, 36'h0);
      chk(b_q, rows[i].e);
      $display("Row %0d done", i);
    end
    fill(9, 8);
    $display("Preset offset test done");
    xfer(0, 4'b0111, 36'h1234abcd5);
    chk(m1_n, 1'b0);
    xfer(1, 4'b0111, 36'h0);
    chk(b_q, 36'h1234abcd5);
    chk({m1_n, b_oe_n}, 36'h2);
    xfer(1, 4'b0011, 36'h0beef0123);
    chk({m2_n, b_oe_n}, 36'h1);
    xfer(0, 4'b0011, 36'h0);
    chk(a_q, 36'h0beef0123);
    chk({m2_n, a_oe_n}, 36'h2);
    $display("Mailbox test done");
    mreset(3'b010);
    for (int k = 15; k >= 0; k--) begin
      @(negedge pac);
      @(posedge i_mclk);
      fs0 <= SER[k];
      fs1 <= 1'b0;
      @(posedge pac);
      repeat (6) @(posedge i_mclk);
      fs1 <= 1'b1;
      chk(full, 1'b0);
    end
    @(posedge pac);
    repeat (6) @(posedge i_mclk);
    chk(full, 1'b1);
    fill(4, 3);
    $display("Serial offset test done");
    // Fall-through from here on; level held through both resets
    tsel <= 1'b0;
    mreset(3'b111);
    chk(full, 1'b1);
    mreset(3'b100);
    chk(full, 1'b1);
    xfer(0, 4'b0110, 36'h004);
    xfer(0, 4'b0110, 36'h002);
    chk(empty, 1'b0);
    xfer(0, 4'b0110, 36'habc);
    repeat (30) @(posedge i_mclk);
    chk(empty, 1'b1);
    // Output word is not counted, so X=2 trips on the third fill
    fill(3, 2);
    xfer(1, 4'b0100, 36'h0);
    chk(b_q, 36'habc);
    xfer(1, 4'b0110, 36'h0);
    chk(b_q, 36'h1);
    $display("Parallel fall-through test done");
    report_and_stop();
  end
endmodule : testbench
